// file: rtl/spc_pkg.sv
`default_nettype none

package spc_pkg;

  // Byte addresses of the special registers held by this block
  localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_BUFFER  = 8'h99;
  localparam logic [7:0] ADDR_TIMER2_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_POWER_CONTROL  = 8'h87;
  localparam logic [7:0] ADDR_IO_CONTROL     = 8'hf8;

  // serial_control field positions
  localparam int SC_RECEIVE_COMPLETE = 0;
  localparam int SC_TRANSMIT_COMPLETE = 1;
  localparam int SC_RECEIVED_NINTH   = 2;
  localparam int SC_TRANSMIT_NINTH   = 3;
  localparam int SC_RECEIVE_ENABLE   = 4;
  localparam int SC_MULTIPROC_FILTER = 5;
  localparam int SC_MODE_LOW         = 6;
  localparam int SC_MODE_HIGH        = 7;

  // Other register field positions
  localparam int T2C_TRANSMIT_CLOCK_SEL = 4;
  localparam int T2C_RECEIVE_CLOCK_SEL  = 5;
  localparam int PC_RATE_DOUBLING       = 7;
  localparam int IOC_SERIAL_ERROR       = 5;

  // Reset values
  localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SERIAL_BUFFER_RESET  = 8'h00;
  localparam logic       CONTROL_BIT_RESET    = 1'b0;

  // Timing: the core clock is the fundamental oscillator
  localparam int         OSC_FREQ_HZ     = 50_000_000;
  localparam logic [3:0] MODE0_DIVIDE    = 4'hc;
  localparam logic [1:0] HALF_OSC_DIVIDE = 2'h2;

  // Operating modes, mode_select_high in bit 1
  typedef enum logic [1:0] {
    SPC_MODE_SHIFT      = 2'b00,
    SPC_MODE_UART10     = 2'b01,
    SPC_MODE_UART11_FIX = 2'b10,
    SPC_MODE_UART11_VAR = 2'b11
  } spc_mode_type;

endpackage : spc_pkg

`default_nettype wire

// file: rtl/spc_baud_sel.sv
`default_nettype none

module spc_baud_sel (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rstn,
  // Configuration
  input  wire spc_pkg::spc_mode_type portMode,
  input  wire logic          rateDoublingBit,
  input  wire logic          transmitClockSelect,
  input  wire logic          receiveClockSelect,
  // Timer overflow strobes
  input  wire logic          timer1Overflow,
  input  wire logic          timer2Overflow,
  // Baud clock enables
  output logic               txBaudTick,
  output logic               rxBaudTick
);
  import spc_pkg::*;

  typedef struct packed {
    logic [3:0] mode0Count;
    logic [1:0] halfOscCount;
    logic       halfOscPhase;
    logic       timer1Phase;
    logic       txTick;
    logic       rxTick;
  } spc_baud_state_type;

  spc_baud_state_type st_q;
  spc_baud_state_type st_d;

  logic mode0Tick;
  logic halfOscTick;
  logic mode2Tick;
  logic timer1Tick;

  always_comb begin
    st_d = st_q;
    mode0Tick = (st_q.mode0Count == MODE0_DIVIDE - 4'h1);
    halfOscTick = (st_q.halfOscCount == HALF_OSC_DIVIDE - 2'h1);
    // Divider runs free so that a mode change never stalls it
    st_d.mode0Count = mode0Tick ? 4'h0 : st_q.mode0Count + 4'h1;
    st_d.halfOscCount = halfOscTick ? 2'h0 : st_q.halfOscCount + 2'h1;
    if (halfOscTick) begin
      st_d.halfOscPhase = ~st_q.halfOscPhase;
    end
    // Mode 2: half oscillator, halved again unless doubled
    mode2Tick = halfOscTick & (rateDoublingBit | st_q.halfOscPhase);
    if (timer1Overflow) begin
      st_d.timer1Phase = ~st_q.timer1Phase;
    end
    // Timer 1 overflow halved unless doubled
    timer1Tick = timer1Overflow &
                 (rateDoublingBit | st_q.timer1Phase);
    case (portMode)
      SPC_MODE_SHIFT: begin
        st_d.txTick = mode0Tick;
        st_d.rxTick = mode0Tick;
      end
      SPC_MODE_UART11_FIX: begin
        st_d.txTick = mode2Tick;
        st_d.rxTick = mode2Tick;
      end
      SPC_MODE_UART10, SPC_MODE_UART11_VAR: begin
        // Timer 2 path never sees the doubling bit
        st_d.txTick = transmitClockSelect ? timer2Overflow
                                          : timer1Tick;
        st_d.rxTick = receiveClockSelect ? timer2Overflow
                                         : timer1Tick;
      end
      default: begin
        st_d.txTick = 1'b0;
        st_d.rxTick = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign txBaudTick = st_q.txTick;
  assign rxBaudTick = st_q.rxTick;

endmodule // spc_baud_sel

`default_nettype wire

// file: rtl/spc_serial_ctrl.sv
`default_nettype none

module spc_serial_ctrl (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rstn,
  // Byte access to special registers
  input  wire logic [7:0]    sfrAddr,
  input  wire logic          sfrWrEn,
  input  wire logic [7:0]    sfrWrData,
  input  wire logic          sfrRdEn,
  output logic [7:0]         sfrRdData,
  // Bit access to bit-addressable registers
  input  wire logic [7:0]    bitAddr,
  input  wire logic          bitWrEn,
  input  wire logic          bitWrVal,
  input  wire logic          bitRdEn,
  output logic               bitRdVal,
  // Timer overflow strobes
  input  wire logic          timer1Overflow,
  input  wire logic          timer2Overflow,
  // Receive shifter
  input  wire logic          rxFrameDone,
  input  wire logic [7:0]    rxData,
  input  wire logic          rxNinthBit,
  input  wire logic          rxStopBit,
  output logic               rxEnable,
  output logic               rxBaudTick,
  // Transmit shifter
  input  wire logic          txFrameDone,
  output logic               txStart,
  output logic [7:0]         txData,
  output logic               txNinthBit,
  output logic               txBaudTick,
  // Mode and interrupt
  output spc_pkg::spc_mode_type portMode,
  output logic               serialIrq
);
  import spc_pkg::*;

  typedef struct packed {
    spc_mode_type mode;
    logic         filter;
    logic         receiveEnable;
    logic         transmitNinth;
    logic         receivedNinth;
    logic         transmitComplete;
    logic         receiveComplete;
    logic         transmitClockSel;
    logic         receiveClockSel;
    logic         rateDoubling;
    logic         serialError;
    logic [7:0]   rxBuffer;
    logic [7:0]   txBuffer;
    logic         txStart;
    logic [7:0]   rdData;
    logic         bitRd;
  } spc_ctrl_state_type;

  spc_ctrl_state_type st_q;
  spc_ctrl_state_type st_d;

  logic [7:0] controlNow;
  logic [7:0] controlWr;
  logic       controlWe;
  logic       bitToControl;
  logic       bitToTimer2;
  logic       bitToIo;
  logic       uartMode;
  logic       acceptOk;
  logic       loadFrame;
  logic       framingError;
  logic       overrunError;
  logic [7:0] bitBase;

  function automatic logic [7:0] packControl(input spc_ctrl_state_type s);
    logic [7:0] v;
    v = 8'h00;
    v[SC_RECEIVE_COMPLETE]  = s.receiveComplete;
    v[SC_TRANSMIT_COMPLETE] = s.transmitComplete;
    v[SC_RECEIVED_NINTH]    = s.receivedNinth;
    v[SC_TRANSMIT_NINTH]    = s.transmitNinth;
    v[SC_RECEIVE_ENABLE]    = s.receiveEnable;
    v[SC_MULTIPROC_FILTER]  = s.filter;
    v[SC_MODE_LOW]          = s.mode[0];
    v[SC_MODE_HIGH]         = s.mode[1];
    return v;
  endfunction

  // Unmapped addresses and unheld bits read as zero
  function automatic logic [7:0] readByte(input logic [7:0] addr,
                                          input spc_ctrl_state_type s);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      ADDR_SERIAL_CONTROL: v = packControl(s);
      ADDR_SERIAL_BUFFER:  v = s.rxBuffer;
      ADDR_TIMER2_CONTROL: begin
        v[T2C_TRANSMIT_CLOCK_SEL] = s.transmitClockSel;
        v[T2C_RECEIVE_CLOCK_SEL]  = s.receiveClockSel;
      end
      ADDR_POWER_CONTROL:  v[PC_RATE_DOUBLING] = s.rateDoubling;
      ADDR_IO_CONTROL:     v[IOC_SERIAL_ERROR] = s.serialError;
      default:             v = 8'h00;
    endcase
    return v;
  endfunction

  // Only the bit-addressable registers answer a bit read
  function automatic logic readBit(input logic [7:0] addr,
                                   input spc_ctrl_state_type s);
    logic [7:0] v;
    v = 8'h00;
    case ({addr[7:3], 3'h0})
      ADDR_SERIAL_CONTROL,
      ADDR_TIMER2_CONTROL,
      ADDR_IO_CONTROL: v = readByte({addr[7:3], 3'h0}, s);
      default:         v = 8'h00;
    endcase
    return v[addr[2:0]];
  endfunction

  always_comb begin
    st_d = st_q;
    controlNow = packControl(st_q);
    bitBase = {bitAddr[7:3], 3'h0};
    // Power control is absent here, so bit access cannot reach it
    bitToControl = bitWrEn & (bitBase == ADDR_SERIAL_CONTROL);
    bitToTimer2  = bitWrEn & (bitBase == ADDR_TIMER2_CONTROL);
    bitToIo      = bitWrEn & (bitBase == ADDR_IO_CONTROL);

    // Byte write wins over a bit write in the same cycle
    controlWe = 1'b0;
    controlWr = controlNow;
    if (sfrWrEn && sfrAddr == ADDR_SERIAL_CONTROL) begin
      controlWe = 1'b1;
      controlWr = sfrWrData;
    end else if (bitToControl) begin
      controlWe = 1'b1;
      controlWr[bitAddr[2:0]] = bitWrVal;
    end
    if (controlWe) begin
      st_d.receiveComplete  = controlWr[SC_RECEIVE_COMPLETE];
      st_d.transmitComplete = controlWr[SC_TRANSMIT_COMPLETE];
      st_d.receivedNinth    = controlWr[SC_RECEIVED_NINTH];
      st_d.transmitNinth    = controlWr[SC_TRANSMIT_NINTH];
      st_d.receiveEnable    = controlWr[SC_RECEIVE_ENABLE];
      st_d.filter           = controlWr[SC_MULTIPROC_FILTER];
      st_d.mode = spc_mode_type'({controlWr[SC_MODE_HIGH],
                                  controlWr[SC_MODE_LOW]});
    end

    // Clock selects: byte write or their own bit addresses
    if (sfrWrEn && sfrAddr == ADDR_TIMER2_CONTROL) begin
      st_d.transmitClockSel = sfrWrData[T2C_TRANSMIT_CLOCK_SEL];
      st_d.receiveClockSel  = sfrWrData[T2C_RECEIVE_CLOCK_SEL];
    end else if (bitToTimer2) begin
      if (bitAddr[2:0] == 3'(T2C_TRANSMIT_CLOCK_SEL)) begin
        st_d.transmitClockSel = bitWrVal;
      end
      if (bitAddr[2:0] == 3'(T2C_RECEIVE_CLOCK_SEL)) begin
        st_d.receiveClockSel = bitWrVal;
      end
    end

    if (sfrWrEn && sfrAddr == ADDR_POWER_CONTROL) begin
      st_d.rateDoubling = sfrWrData[PC_RATE_DOUBLING];
    end

    if (sfrWrEn && sfrAddr == ADDR_IO_CONTROL) begin
      st_d.serialError = sfrWrData[IOC_SERIAL_ERROR];
    end else if (bitToIo && bitAddr[2:0] == 3'(IOC_SERIAL_ERROR)) begin
      st_d.serialError = bitWrVal;
    end

    // Transmit holding register never touches the received value
    st_d.txStart = 1'b0;
    if (sfrWrEn && sfrAddr == ADDR_SERIAL_BUFFER) begin
      st_d.txBuffer = sfrWrData;
      st_d.txStart  = 1'b1;
    end

    // Acceptance filter per mode
    uartMode = (st_q.mode != SPC_MODE_SHIFT);
    case (st_q.mode)
      SPC_MODE_SHIFT:  acceptOk = 1'b1;
      SPC_MODE_UART10: acceptOk = ~st_q.filter | rxStopBit;
      SPC_MODE_UART11_FIX,
      SPC_MODE_UART11_VAR: acceptOk = ~st_q.filter | rxNinthBit;
      default:         acceptOk = 1'b0;
    endcase
    // A set flag means the buffer still holds unread data
    loadFrame = rxFrameDone & acceptOk &
                ~st_q.receiveComplete;
    framingError = rxFrameDone & uartMode & ~rxStopBit;
    overrunError = rxFrameDone & uartMode & acceptOk &
                   st_q.receiveComplete;

    // Hardware events override a software write in the same cycle
    if (loadFrame) begin
      st_d.rxBuffer = rxData;
      st_d.receiveComplete = 1'b1;
      if (uartMode) begin
        st_d.receivedNinth = (st_q.mode == SPC_MODE_UART10) ?
                             rxStopBit : rxNinthBit;
      end
    end
    if (txFrameDone) begin
      st_d.transmitComplete = 1'b1;
    end
    if (framingError || overrunError) begin
      st_d.serialError = 1'b1;
    end

    // Read data is registered and valid the cycle after the strobe
    if (sfrRdEn) begin
      st_d.rdData = readByte(sfrAddr, st_q);
    end
    if (bitRdEn) begin
      st_d.bitRd = readBit(bitAddr, st_q);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{
        mode:             SPC_MODE_SHIFT,
        filter:           CONTROL_BIT_RESET,
        receiveEnable:    CONTROL_BIT_RESET,
        transmitNinth:    CONTROL_BIT_RESET,
        receivedNinth:    CONTROL_BIT_RESET,
        transmitComplete: CONTROL_BIT_RESET,
        receiveComplete:  CONTROL_BIT_RESET,
        transmitClockSel: CONTROL_BIT_RESET,
        receiveClockSel:  CONTROL_BIT_RESET,
        rateDoubling:     CONTROL_BIT_RESET,
        serialError:      CONTROL_BIT_RESET,
        rxBuffer:         SERIAL_BUFFER_RESET,
        txBuffer:         SERIAL_BUFFER_RESET,
        txStart:          1'b0,
        rdData:           8'h00,
        bitRd:            1'b0
      };
    end else begin
      st_q <= st_d;
    end
  end

  spc_baud_sel spc_baud_sel_inst (
    .core_clk            (core_clk),
    .rstn                (rstn),
    .portMode            (st_q.mode),
    .rateDoublingBit     (st_q.rateDoubling),
    .transmitClockSelect (st_q.transmitClockSel),
    .receiveClockSelect  (st_q.receiveClockSel),
    .timer1Overflow      (timer1Overflow),
    .timer2Overflow      (timer2Overflow),
    .txBaudTick          (txBaudTick),
    .rxBaudTick          (rxBaudTick)
  );

  assign sfrRdData  = st_q.rdData;
  assign bitRdVal   = st_q.bitRd;
  // Shifter must not start a frame while this is low
  assign rxEnable   = st_q.receiveEnable;
  assign txStart    = st_q.txStart;
  assign txData     = st_q.txBuffer;
  assign txNinthBit = st_q.transmitNinth;
  assign portMode   = st_q.mode;
  // The error flag deliberately stays out of the request
  assign serialIrq  = st_q.receiveComplete |
                      st_q.transmitComplete;

endmodule // spc_serial_ctrl

`default_nettype wire

// file: testbench/spc_serial_ctrl_props.sv
`default_nettype none

module spc_serial_ctrl_props (
  // Clock and reset
  input wire logic           core_clk,
  input wire logic           rstn,
  // Register access
  input wire logic [7:0]     sfrAddr,
  input wire logic           sfrWrEn,
  input wire logic [7:0]     sfrWrData,
  input wire logic [7:0]     bitAddr,
  input wire logic           bitWrEn,
  // Shifters, timers and status
  input wire logic           timer1Overflow,
  input wire logic           timer2Overflow,
  input wire logic           rxFrameDone,
  input wire logic           txFrameDone,
  input wire logic           rxEnable,
  input wire logic           rxBaudTick,
  input wire logic           txStart,
  input wire logic [7:0]     txData,
  input wire logic           txNinthBit,
  input var spc_pkg::spc_mode_type portMode,
  input wire logic           serialIrq
);
  timeunit 1ns;
  timeprecision 1ns;
  import spc_pkg::*;

  logic wrCtrl;
  logic wrBuf;
  logic swTouch;
  assign wrCtrl = sfrWrEn && sfrAddr == ADDR_SERIAL_CONTROL;
  assign wrBuf = sfrWrEn && sfrAddr == ADDR_SERIAL_BUFFER;
  // Any software path that may legally clear a flag
  assign swTouch = wrCtrl || (bitWrEn && bitAddr[7:3] == 5'h13);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  mode_write_a: assert property (wrCtrl |=>
    portMode == $past(sfrWrData[7:6])) else $error("mode not taken");
  rx_enable_a: assert property (wrCtrl |=>
    rxEnable == $past(sfrWrData[4])) else $error("enable not taken");
  tx_ninth_a: assert property (wrCtrl |=>
    txNinthBit == $past(sfrWrData[3])) else $error("ninth not taken");
  tx_load_a: assert property (wrBuf |=>
    txStart && txData == $past(sfrWrData)) else $error("tx load bad");
  tx_cause_a: assert property (txStart |-> $past(wrBuf))
    else $error("tx start without write");
  tx_flag_a: assert property (txFrameDone |=> serialIrq)
    else $error("tx flag not set");
  rx_flag_a: assert property (
    rxFrameDone && portMode == SPC_MODE_SHIFT |=> serialIrq)
    else $error("rx flag not set");
  flag_hold_a: assert property (
    serialIrq && !swTouch |=> serialIrq) else $error("flag cleared");
  shift_tick_a: assert property (
    portMode == SPC_MODE_SHIFT && $stable(portMode) && rxBaudTick |=>
    (!rxBaudTick || portMode != SPC_MODE_SHIFT) [*8] ##1
    (!rxBaudTick || portMode != SPC_MODE_SHIFT) [*3] ##1
    (rxBaudTick || portMode != SPC_MODE_SHIFT))
    else $error("shift tick spacing");
  uart_tick_a: assert property (
    rxBaudTick && portMode[0] && $stable(portMode) |->
    $past(timer1Overflow) || $past(timer2Overflow))
    else $error("uart tick without overflow");

  cover property (rxFrameDone && rxEnable);
  cover property (txStart);
  cover property (txFrameDone);
endmodule // spc_serial_ctrl_props

`default_nettype wire

// file: testbench/spc_far_model.sv
`default_nettype none

module spc_far_model #(
  parameter int TX_DELAY  = 40,
  parameter int T1_PERIOD = 4,
  parameter int T2_PERIOD = 6
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rstn,
  // Frame requests from the bench
  input wire logic       frameReq,
  input wire logic [7:0] reqData,
  input wire logic       reqNinth,
  input wire logic       reqStop,
  // Block side
  input wire logic       rxEnable,
  input wire logic       txStart,
  output logic           timer1Overflow,
  output logic           timer2Overflow,
  output logic           rxFrameDone,
  output logic [7:0]     rxData,
  output logic           rxNinthBit,
  output logic           rxStopBit,
  output logic           txFrameDone
);
  timeunit 1ns;
  timeprecision 1ns;

  int  t1Cnt;
  int  t2Cnt;
  int  txCnt;
  logic take;
  // Shifter only starts a frame while reception is enabled
  assign take = frameReq && rxEnable;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      t1Cnt <= 0;
      t2Cnt <= 0;
      txCnt <= 0;
      timer1Overflow <= 1'b0;
      timer2Overflow <= 1'b0;
      rxFrameDone <= 1'b0;
      rxData <= 8'h00;
      rxNinthBit <= 1'b0;
      rxStopBit <= 1'b0;
      txFrameDone <= 1'b0;
    end else begin
      t1Cnt <= (t1Cnt == T1_PERIOD - 1) ? 0 : t1Cnt + 1;
      t2Cnt <= (t2Cnt == T2_PERIOD - 1) ? 0 : t2Cnt + 1;
      timer1Overflow <= (t1Cnt == T1_PERIOD - 1);
      timer2Overflow <= (t2Cnt == T2_PERIOD - 1);
      rxFrameDone <= take;
      // Idle lines toggle so stale data never passes for valid
      rxData <= take ? reqData : ~rxData;
      rxNinthBit <= take ? reqNinth : ~rxNinthBit;
      rxStopBit <= take ? reqStop : ~rxStopBit;
      txFrameDone <= (txCnt == 1);
      txCnt <= txStart ? TX_DELAY : (txCnt > 0 ? txCnt - 1 : 0);
    end
  end
endmodule // spc_far_model

`default_nettype wire

// file: testbench/spc_serial_ctrl_test.sv
`default_nettype none

module spc_serial_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  import spc_pkg::*;

  logic       core_clk = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic       sfrWrEn = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic       sfrRdEn = 1'b0;
  logic [7:0] bitAddr = 8'h00;
  logic       bitWrEn = 1'b0;
  logic       bitWrVal = 1'b0;
  logic       bitRdEn = 1'b0;
  logic       frameReq = 1'b0;
  logic [7:0] reqData = 8'h00;
  logic       reqNinth = 1'b0;
  logic       reqStop = 1'b0;
  logic [7:0] sfrRdData, rxData, txData;
  logic bitRdVal, rxEnable, rxBaudTick, txStart, txNinthBit;
  logic txBaudTick, serialIrq, timer1Overflow, timer2Overflow;
  logic rxFrameDone, rxNinthBit, rxStopBit, txFrameDone;
  spc_mode_type portMode;
  int n_fail = 0;
  int num_checks = 0;

  always #10 core_clk = ~core_clk;

  spc_serial_ctrl spc_serial_ctrl_inst (
    .core_clk, .rstn, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn,
    .sfrRdData, .bitAddr, .bitWrEn, .bitWrVal, .bitRdEn, .bitRdVal,
    .timer1Overflow, .timer2Overflow, .rxFrameDone, .rxData,
    .rxNinthBit, .rxStopBit, .rxEnable, .rxBaudTick, .txFrameDone,
    .txStart, .txData, .txNinthBit, .txBaudTick, .portMode, .serialIrq
  );
  spc_far_model #(.TX_DELAY(40)) spc_far_model_inst (
    .core_clk, .rstn, .frameReq, .reqData, .reqNinth, .reqStop,
    .rxEnable, .txStart, .timer1Overflow, .timer2Overflow,
    .rxFrameDone, .rxData, .rxNinthBit, .rxStopBit, .txFrameDone
  );

  task automatic results;
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfrWrEn <= 1'b1;
    sfrAddr <= a;
    sfrWrData <= d;
    @(posedge core_clk);
    sfrWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    sfrRdEn <= 1'b1;
    sfrAddr <= a;
    @(posedge core_clk);
    sfrRdEn <= 1'b0;
    #1 chk(sfrRdData, e);
  endtask

  task automatic bwr(input logic [7:0] a, input logic v);
    @(posedge core_clk);
    bitWrEn <= 1'b1;
    bitAddr <= a;
    bitWrVal <= v;
    @(posedge core_clk);
    bitWrEn <= 1'b0;
  endtask

  task automatic brd(input logic [7:0] a, input logic e);
    @(posedge core_clk);
    bitRdEn <= 1'b1;
    bitAddr <= a;
    @(posedge core_clk);
    bitRdEn <= 1'b0;
    #1 chk({7'h00, bitRdVal}, {7'h00, e});
  endtask

  task automatic frame(input logic [7:0] d, input logic n9, input logic st);
    @(posedge core_clk);
    frameReq <= 1'b1;
    reqData <= d;
    reqNinth <= n9;
    reqStop <= st;
    @(posedge core_clk);
    frameReq <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  // Ticks counted over 240 cycles, a whole number of every period
  task automatic baud(input logic [7:0] sc, t2, pc, et, er);
    logic [7:0] nt;
    logic [7:0] nr;
    wr(8'h98, sc);
    wr(8'hc8, t2);
    wr(8'h87, pc);
    repeat (30) @(posedge core_clk);
    nt = 8'h00;
    nr = 8'h00;
    repeat (240) begin
      @(posedge core_clk);
      #1;
      nt = nt + txBaudTick;
      nr = nr + rxBaudTick;
    end
    chk(nt, et);
    chk(nr, er);
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    rd(8'h98, SERIAL_CONTROL_RESET);
    wr(8'h90, 8'hff);
    rd(8'h90, 8'h00);
    wr(8'h87, 8'hff);
    bwr(8'h87, 1'b0);
    rd(8'h87, 8'h80);
    bwr(8'hcc, 1'b1);
    rd(8'hc8, 8'h10);
    wr(8'h98, 8'h50);
    frame(8'ha5, 1'b0, 1'b1);
    rd(8'h99, 8'ha5);
    rd(8'h98, 8'h55);
    frame(8'h3c, 1'b0, 1'b1);
    rd(8'h99, 8'ha5);
    brd(8'hfd, 1'b1);
    wr(8'hf8, 8'h00);
    bwr(8'h98, 1'b0);
    brd(8'h98, 1'b0);
    wr(8'h98, 8'h70);
    frame(8'h77, 1'b0, 1'b0);
    rd(8'h98, 8'h70);
    rd(8'hf8, 8'h20);
    wr(8'hf8, 8'h00);
    wr(8'h98, 8'hf0);
    frame(8'h11, 1'b0, 1'b1);
    rd(8'h98, 8'hf0);
    frame(8'h22, 1'b1, 1'b1);
    rd(8'h98, 8'hf5);
    rd(8'hf8, 8'h00);
    wr(8'h98, 8'h10);
    frame(8'h66, 1'b1, 1'b0);
    rd(8'h99, 8'h66);
    rd(8'h98, 8'h11);
    wr(8'h98, 8'hc8);
    wr(8'h99, 8'h5a);
    #1 chk(txData, 8'h5a);
    chk({7'h00, txNinthBit}, 8'h01);
    frame(8'h99, 1'b1, 1'b1);
    rd(8'h99, 8'h66);
    rd(8'h99, 8'h66);
    for (int i = 0; i < 200 && serialIrq !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (serialIrq !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t transmit flag timeout", $time);
    end
    rd(8'h98, 8'hca);
    wr(8'h98, 8'h00);
    #1 chk({7'h00, serialIrq}, 8'h00);
    baud(8'h00, 8'h30, 8'h00, 8'd20, 8'd20);
    baud(8'h80, 8'h00, 8'h80, 8'd120, 8'd120);
    baud(8'h80, 8'h30, 8'h00, 8'd60, 8'd60);
    baud(8'h40, 8'h00, 8'h00, 8'd30, 8'd30);
    baud(8'h40, 8'h10, 8'h80, 8'd40, 8'd60);
    baud(8'hc0, 8'h20, 8'h00, 8'd30, 8'd40);
    baud(8'h40, 8'h30, 8'h80, 8'd40, 8'd40);
    results();
  end
endmodule // spc_serial_ctrl_test

bind spc_serial_ctrl spc_serial_ctrl_props spc_serial_ctrl_props_inst (
  .core_clk, .rstn, .sfrAddr, .sfrWrEn, .sfrWrData, .bitAddr, .bitWrEn,
  .timer1Overflow, .timer2Overflow, .rxFrameDone, .txFrameDone,
  .rxEnable, .rxBaudTick, .txStart, .txData, .txNinthBit, .portMode,
  .serialIrq
);

`default_nettype wire
